// file: core/emc_pkg.sv
/*
 * Constants shared by the external memory controller: register offsets,
 * field positions, reset values, address space sizes and clock ratios.
 * Assumes a single 100 MHz system clock and a plain register port.
 */
package emc_pkg;

	// Register offsets on the plain register port (byte addresses).
	localparam logic [3:0] CFG_ADDR     = 4'h0;
	localparam logic [3:0] OVERLAY_ADDR = 4'h4;
	localparam logic [3:0] STATUS_ADDR  = 4'h8;

	// Configuration register field positions.
	localparam int CFG_CODE_WIDE_BIT = 0;
	localparam int CFG_CODE_X16_BIT  = 1;
	localparam int CFG_DATA_WIDE_BIT = 2;
	localparam int CFG_DATA_X16_BIT  = 3;
	localparam int CFG_FAST_BIT      = 4;
	localparam int CFG_USB_BIT       = 5;

	// Reset values.
	localparam logic [5:0] CFG_RESET     = 6'h00;
	localparam logic [7:0] OVERLAY_RESET = 8'h00;

	// External address width: 4 Mbytes is 22 bits of byte address.
	localparam int ADDR_W = 22;
	// With USB as host interface only 1 Mbyte (20 bits) is reachable.
	localparam logic [21:0] USB_ADDR_MASK = 22'h0fffff;
	localparam logic [21:0] FULL_ADDR_MASK = 22'h3fffff;

	// Code space is 128 Kbytes (17 bits) in eight 16 Kbyte sections.
	localparam int CODE_ADDR_W   = 17;
	localparam int SECTION_SHIFT = 14;
	localparam int SECTIONS      = 8;

	// Internal ROM occupies the lowest code section; not readable as data.
	localparam logic [2:0] ROM_SECTION = 3'h0;

	// Strobe length in clocks: slow after reset, fast once raised.
	localparam logic [3:0] SLOW_CYCLES = 4'h8;
	localparam logic [3:0] FAST_CYCLES = 4'h2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCESS,
		ST_DONE
	} mem_state_type;

endpackage

// file: core/external_memory_controller.sv
/*
 * External memory controller: separate code and data chip selects,
 * 8/16-bit spaces with a shared byte pin, a code overlay into data RAM
 * and a slow instruction clock after reset.
 * Assumes the internal core issues one access at a time and holds it
 * until done_o, and that each memory space uses one memory type only.
 */
`timescale 1ns/100ps

// Operation
// - Separate chip selects for code and data.
// - Address limit 4 Mbytes, 1 Mbyte with USB.
// - Overlay maps 16 KB sections from top down.
// - Code readable as data except internal ROM.
// - Slow instruction clock until firmware raises it.
// - Code and data each 8 or 16 bits.
// - Strap sampled after reset picks data memory type.
// - 8-bit: shared pin is address LSB.
// - Two x8: shared pin is high write enable.
// - Single x16: shared pin is upper byte enable.
// - Shared pin role chosen per access space.
module external_memory_controller (
	input  wire logic        clk_i,           // 100 MHz system clock.
	input  wire logic        sys_rst_i,       // Synchronous reset, high.
	input  wire logic [3:0]  reg_addr_i,      // Register byte address.
	input  wire logic [31:0] reg_wdata_i,     // Register write data.
	input  wire logic        reg_wr_i,        // Register write strobe.
	input  wire logic        reg_rd_i,        // Register read strobe.
	output logic      [31:0] reg_rdata_o,     // Read data, next cycle.
	input  wire logic [1:0]  config_strap_pins_i, // Memory type straps.
	input  wire logic        req_i,           // Core access request.
	input  wire logic        req_data_i,      // 1 data space, 0 code.
	input  wire logic        req_write_i,     // 1 write, 0 read.
	input  wire logic [21:0] req_addr_i,      // Byte address in space.
	input  wire logic [1:0]  req_be_i,        // Byte enables, bit1 high.
	output logic             done_o,          // Access finished pulse.
	output logic             fast_clk_o,      // Instruction clock fast.
	output logic             code_cs_n_o,     // Code space chip select.
	output logic             data_cs_n_o,     // Data space chip select.
	output logic      [21:0] mem_addr_o,      // External address.
	output logic             shared_byte_pin_n_o, // Shared byte pin.
	output logic             low_write_strobe_n_o, // Low write strobe.
	output logic             read_output_strobe_n_o, // Read strobe.
	output logic             low_byte_strobe_n_o // Low byte enable.
);

	// Firmware-visible state. The configuration bits pick widths, styles,
	// clock speed and the USB address limit; the overlay byte holds one
	// enable per 16 Kbyte code section.
	logic [5:0]                 cfg_q, cfg_d;
	logic [7:0]                 ovl_q, ovl_d;
	logic [31:0]                rdata_q, rdata_d;
	// Strap level as seen just after reset, and whether it was taken.
	logic [1:0]                 strap_q, strap_d;
	logic                       strap_take_q, strap_take_d;
	// Access sequencer and the registered pin images. Every pin leaves a
	// flop so that the memory chips never see decode glitches.
	emc_pkg::mem_state_type     state_q, state_d;
	logic [3:0]                 cnt_q, cnt_d;
	logic                       cs_code_q, cs_code_d;
	logic                       cs_data_q, cs_data_d;
	logic [21:0]                addr_q, addr_d;
	logic                       sbp_q, sbp_d;
	logic                       wel_q, wel_d;
	logic                       oe_q, oe_d;
	logic                       lbe_q, lbe_d;
	// Decode results for the access in progress; combinational only.
	logic                       wide, x16, to_data, rom_hit;
	logic [2:0]                 sect;
	logic [21:0]                eff_addr, mask;

	// Register file; writes steer widths, overlay and clock speed.
	always_comb
	begin
		cfg_d   = cfg_q;
		ovl_d   = ovl_q;
		rdata_d = 32'h00000000;
		// Unmapped offsets fall through and the write is dropped.
		if (reg_wr_i)
		begin
			if (reg_addr_i == emc_pkg::CFG_ADDR)
				cfg_d = reg_wdata_i[5:0];
			else if (reg_addr_i == emc_pkg::OVERLAY_ADDR)
				ovl_d = reg_wdata_i[7:0];
		end
		// Read data are parked at zero outside the answer cycle, so a
		// stale value is never mistaken for an answer.
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				emc_pkg::CFG_ADDR:     rdata_d = {26'h0, cfg_q};
				emc_pkg::OVERLAY_ADDR: rdata_d = {24'h0, ovl_q};
				emc_pkg::STATUS_ADDR:
					rdata_d = {28'h0, state_q != emc_pkg::ST_IDLE,
						strap_take_q, strap_q};
				default:               rdata_d = 32'h00000000;
			endcase
		end
	end

	// Overlays cleared and slow clock selected at reset.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			cfg_q   <= emc_pkg::CFG_RESET;
			ovl_q   <= emc_pkg::OVERLAY_RESET;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			cfg_q   <= cfg_d;
			ovl_q   <= ovl_d;
			rdata_q <= rdata_d;
		end
	end

	// Instruction clock speed is a plain configuration bit. Speed is never
	// sensed from the memories: firmware raises it only once code runs
	// from RAM, so slow Flash stays safe until then.
	assign reg_rdata_o = rdata_q;
	assign fast_clk_o  = cfg_q[emc_pkg::CFG_FAST_BIT];

	// Strap capture: taken on the first clock after reset release, since
	// a reset flop may only load constants.
	// Taking it once keeps a strap pin that later carries other traffic
	// from changing the memory style under running code.
	always_comb
	begin
		strap_d      = strap_q;
		strap_take_d = strap_take_q;
		if (!strap_take_q)
		begin
			strap_d      = config_strap_pins_i;
			strap_take_d = 1'b1;
		end
	end

	// The strap flops only load constants in reset.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			strap_q      <= 2'h0;
			strap_take_q <= 1'b0;
		end
		else
		begin
			strap_q      <= strap_d;
			strap_take_q <= strap_take_d;
		end
	end

	// Space decode. The strap can force the data wide and x16 style bits on;
	// firmware can add to them through the configuration bits but not clear them.
	always_comb
	begin
		sect    = req_addr_i[16:14];
		to_data = req_data_i;
		rom_hit = 1'b0;
		eff_addr = req_addr_i;
		// Code fetch in an enabled section goes to the top of data RAM.
		if (!req_data_i && ovl_q[sect])
		begin
			to_data  = 1'b1;
			eff_addr = emc_pkg::FULL_ADDR_MASK - 22'h01ffff
				+ {5'h0, req_addr_i[16:0]};
		end
		// Internal ROM is never reachable as data.
		if (!req_data_i && !ovl_q[sect] && sect == emc_pkg::ROM_SECTION
			&& req_addr_i[21])
			rom_hit = 1'b1;
		// The USB limit is applied last, so an overlaid fetch still lands
		// at the top of whatever range is reachable.
		mask = cfg_q[emc_pkg::CFG_USB_BIT] ? emc_pkg::USB_ADDR_MASK
			: emc_pkg::FULL_ADDR_MASK;
		eff_addr = eff_addr & mask;
		// Data style may be forced by the strap; code style comes from
		// firmware alone, as code usually sits in a cheap x8 Flash.
		if (to_data)
		begin
			wide = cfg_q[emc_pkg::CFG_DATA_WIDE_BIT] | strap_q[1];
			x16  = cfg_q[emc_pkg::CFG_DATA_X16_BIT] | strap_q[0];
		end
		else
		begin
			wide = cfg_q[emc_pkg::CFG_CODE_WIDE_BIT];
			x16  = cfg_q[emc_pkg::CFG_CODE_X16_BIT];
		end
	end

	// Access sequencer and pin roles for each style of space.
	always_comb
	begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		cs_code_d = 1'b1;
		cs_data_d = 1'b1;
		addr_d    = addr_q;
		sbp_d     = 1'b1;
		wel_d     = 1'b1;
		oe_d      = 1'b1;
		lbe_d     = 1'b1;
		done_o    = 1'b0;
		case (state_q)
			emc_pkg::ST_IDLE:
				// A ROM hit is answered at once with no pin movement,
				// since the internal ROM is not reachable from outside.
				if (req_i && !rom_hit)
				begin
					state_d = emc_pkg::ST_ACCESS;
					cnt_d   = fast_clk_o ? emc_pkg::FAST_CYCLES
						: emc_pkg::SLOW_CYCLES;
				end
				else if (req_i)
					state_d = emc_pkg::ST_DONE;
			emc_pkg::ST_ACCESS:
			begin
				// Only the select of the space in use goes low.
				cs_code_d = to_data;
				cs_data_d = !to_data;
				oe_d      = req_write_i;
				addr_d    = eff_addr;
				// The shared byte pin changes role with the style of the
				// space in use, so mixed spaces need no glue logic.
				if (!wide)
				begin
					sbp_d = eff_addr[0];
					wel_d = !req_write_i;
				end
				else if (!x16)
				begin
					sbp_d = !(req_write_i && req_be_i[1]);
					wel_d = !(req_write_i && req_be_i[0]);
				end
				else
				begin
					sbp_d = !req_be_i[1];
					lbe_d = !req_be_i[0];
					wel_d = !req_write_i;
				end
				// The strobe length counts down; the last count ends it.
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1)
					state_d = emc_pkg::ST_DONE;
			end
			emc_pkg::ST_DONE:
			begin
				// One-cycle answer; the core drops its request after it.
				done_o  = 1'b1;
				state_d = emc_pkg::ST_IDLE;
			end
			default:
				state_d = emc_pkg::ST_IDLE;
		endcase
	end

	// Select and strobe images return to their idle high level in reset, so no chip
	// sees a stray select while the core is held.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			state_q   <= emc_pkg::ST_IDLE;
			cnt_q     <= 4'h0;
			cs_code_q <= 1'b1;
			cs_data_q <= 1'b1;
			addr_q    <= 22'h000000;
			sbp_q     <= 1'b1;
			wel_q     <= 1'b1;
			oe_q      <= 1'b1;
			lbe_q     <= 1'b1;
		end
		else
		begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			cs_code_q <= cs_code_d;
			cs_data_q <= cs_data_d;
			addr_q    <= addr_d;
			sbp_q     <= sbp_d;
			wel_q     <= wel_d;
			oe_q      <= oe_d;
			lbe_q     <= lbe_d;
		end
	end

	// Every memory pin is a flop output; the selects keep the two spaces
	// apart, never both low at once.
	assign code_cs_n_o            = cs_code_q;
	assign data_cs_n_o            = cs_data_q;
	assign mem_addr_o             = addr_q;
	assign shared_byte_pin_n_o    = sbp_q;
	assign low_write_strobe_n_o   = wel_q;
	assign read_output_strobe_n_o = oe_q;
	assign low_byte_strobe_n_o    = lbe_q;

endmodule

// file: verif/emc_monitor.sv
/* Port assertions for the external memory controller.
   Assumes it is bound to the controller's top module. */
`timescale 1ns/100ps
module emc_monitor (
	input wire logic clk_i,                  // Clock.
	input wire logic sys_rst_i,              // Reset.
	input wire logic reg_wr_i,               // Register write.
	input wire logic req_i,                  // Request.
	input wire logic req_write_i,            // Write access.
	input wire logic done_o,                 // Done.
	input wire logic fast_clk_o,             // Fast clock.
	input wire logic code_cs_n_o,            // Code select.
	input wire logic data_cs_n_o,            // Data select.
	input wire logic low_write_strobe_n_o,   // Write strobe.
	input wire logic read_output_strobe_n_o  // Read strobe.
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// Each space has its own select, never both at once.
	cs_excl_a: assert property (code_cs_n_o || data_cs_n_o)
		else $error("both selects low");
	data_cs_cause_a: assert property (!data_cs_n_o |-> $past(req_i))
		else $error("data select without request");
	// Strobes only move while some space is selected.
	strobe_idle_a: assert property ((code_cs_n_o && data_cs_n_o) |->
		(low_write_strobe_n_o && read_output_strobe_n_o))
		else $error("strobe without select");
	rd_cause_a: assert property (!read_output_strobe_n_o |->
		$past(req_i && !req_write_i))
		else $error("read strobe without read");
	wr_cause_a: assert property (!low_write_strobe_n_o |->
		$past(req_i && req_write_i))
		else $error("write strobe without write");
	done_pulse_a: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	// A slow access is the longest; a hung state machine shows here.
	access_bound_a: assert property ($rose(req_i) |-> ##[1:12] done_o)
		else $error("access did not finish");
	fast_cause_a: assert property ($changed(fast_clk_o) |->
		$past(reg_wr_i))
		else $error("clock speed moved by itself");
endmodule

bind external_memory_controller emc_monitor u_mon (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
	.req_i(req_i), .req_write_i(req_write_i), .done_o(done_o),
	.fast_clk_o(fast_clk_o), .code_cs_n_o(code_cs_n_o),
	.data_cs_n_o(data_cs_n_o), .low_write_strobe_n_o(low_write_strobe_n_o),
	.read_output_strobe_n_o(read_output_strobe_n_o)
);

// file: verif/mem_chips_model.sv
/* Behavioural model of the external memory chips.
   Assumes pins are registered outputs of the controller. */
`timescale 1ns/100ps
module mem_chips_model (
	input  wire logic        clk_i,       // Clock.
	input  wire logic        code_cs_n_i, // Code select.
	input  wire logic        data_cs_n_i, // Data select.
	input  wire logic [21:0] addr_i,      // Address.
	input  wire logic [3:0]  pins_i,      // Shared, write, read, low.
	output logic      [21:0] addr_o,      // Last address seen.
	output logic      [3:0]  pins_o,      // Last strobes seen.
	output logic             data_o,      // Last access was data.
	output logic      [7:0]  hits_o = 8'h00 // Selects seen.
);
	logic sel_q = 1'b0;

	// Each space is one chip type, so the pins are kept as seen.
	always @(posedge clk_i)
	begin
		sel_q <= !(code_cs_n_i && data_cs_n_i);
		if (!(code_cs_n_i && data_cs_n_i))
		begin
			addr_o <= addr_i;
			pins_o <= pins_i;
			data_o <= !data_cs_n_i;
			if (!sel_q)
				hits_o <= hits_o + 8'h01;
		end
	end
endmodule

// file: verif/test_external_memory_controller.sv
/* Self-checking bench for the external memory controller.
   Assumes straps tie data space to a single x16 chip. */
`timescale 1ns/100ps
module test_external_memory_controller;
	logic        clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0, req_i = 1'b0, req_data_i = 1'b0;
	logic        req_write_i = 1'b0, done_o, fast_clk_o, m_data;
	logic        code_cs_n_o, data_cs_n_o, sb_n, lw_n, oe_n, lb_n;
	logic [1:0]  strap = 2'h3, req_be_i = 2'h3;
	logic [3:0]  reg_addr_i = 4'h0, m_pins;
	logic [7:0]  h0, m_hits;
	logic [21:0] req_addr_i = 22'h0, mem_addr_o, m_addr;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rv;
	int          num_errors = 0, checked = 0, cyc = 0, ns, nf;

	external_memory_controller dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .config_strap_pins_i(strap),
		.req_i(req_i), .req_data_i(req_data_i), .req_write_i(req_write_i),
		.req_addr_i(req_addr_i), .req_be_i(req_be_i), .done_o(done_o),
		.fast_clk_o(fast_clk_o), .code_cs_n_o(code_cs_n_o),
		.data_cs_n_o(data_cs_n_o), .mem_addr_o(mem_addr_o),
		.shared_byte_pin_n_o(sb_n), .low_write_strobe_n_o(lw_n),
		.read_output_strobe_n_o(oe_n), .low_byte_strobe_n_o(lb_n)
	);
	mem_chips_model u_mem (
		.clk_i(clk_i), .code_cs_n_i(code_cs_n_o), .data_cs_n_i(data_cs_n_o),
		.addr_i(mem_addr_o), .pins_i({sb_n, lw_n, oe_n, lb_n}),
		.addr_o(m_addr), .pins_o(m_pins), .data_o(m_data), .hits_o(m_hits)
	);

	always #5 clk_i = ~clk_i;

	// The whole run needs far fewer cycles; a hang ends here.
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		chk(reg_rdata_o, exp);
	endtask

	// Request is held until done, then dropped for a cycle.
	task automatic acc(input logic d, w, input logic [21:0] a,
		input logic [1:0] be, output int n);
		n = 0;
		@(posedge clk_i);
		req_data_i <= d;
		req_write_i <= w;
		req_addr_i <= a;
		req_be_i <= be;
		req_i <= 1'b1;
		do
		begin
			@(negedge clk_i);
			n++;
		end
		while (done_o !== 1'b1 && n < 40);
		if (done_o !== 1'b1)
		begin
			num_errors++;
			$display("[ERR] %0t access never finished", $time);
		end
		@(posedge clk_i);
		req_i <= 1'b0;
	endtask

	task automatic complete_run();
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(emc_pkg::CFG_ADDR, 32'h0);
		rd(emc_pkg::OVERLAY_ADDR, 32'h0);
		rd(emc_pkg::STATUS_ADDR, 32'h7);
		acc(1'b0, 1'b0, 22'h000003, 2'h3, ns);
		chk({m_data, m_addr}, {1'b0, 22'h000003});
		chk(m_pins[3:1], 3'b110);
		wr(emc_pkg::CFG_ADDR, 32'h1);
		acc(1'b0, 1'b1, 22'h000010, 2'h2, nf);
		chk(m_pins[3:1], 3'b011);
		acc(1'b1, 1'b1, 22'h000020, 2'h1, nf);
		chk({m_data, m_pins}, 5'h1a);
		// Slow and fast runs of one access differ by the strobe lengths.
		wr(emc_pkg::CFG_ADDR, 32'h10);
		acc(1'b0, 1'b0, 22'h000005, 2'h3, nf);
		chk(32'(fast_clk_o), 32'h1);
		chk(32'(ns - nf), 32'h6);
		wr(emc_pkg::OVERLAY_ADDR, 32'h80);
		rd(emc_pkg::OVERLAY_ADDR, 32'h80);
		acc(1'b0, 1'b0, 22'h01c004, 2'h3, nf);
		chk({m_data, m_addr[21:14]}, 9'h1ff);
		acc(1'b0, 1'b0, 22'h018000, 2'h3, nf);
		chk(m_data, 1'b0);
		h0 = m_hits;
		acc(1'b0, 1'b0, 22'h200000, 2'h3, nf);
		chk(m_hits, h0);
		wr(emc_pkg::CFG_ADDR, 32'h13);
		acc(1'b0, 1'b1, 22'h000040, 2'h2, nf);
		chk({m_data, m_pins}, 5'h03);
		chk(m_addr, 22'h000040);
		wr(emc_pkg::CFG_ADDR, 32'h30);
		wr(4'hc, 32'h0);
		rd(emc_pkg::CFG_ADDR, 32'h30);
		acc(1'b1, 1'b0, 22'h3ffffe, 2'h3, nf);
		chk(m_addr, 22'h0ffffe);
		complete_run();
	end
endmodule
